// [common/ddc_consts.svh]
// constants of the dual dac serial control block
// assumes inclusion by bare name from rtl and common files
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH
`define DDC_FRAME_BITS 16
`define DDC_CNT_W 5
`define DDC_CNT_LAST 5'h0F
`define DDC_CNT_FULL 5'h10
`define DDC_WORD_W 16
`define DDC_CODE_W 12
`define DDC_RES_DEFAULT 12
`define DDC_SEL_BIT 15
`define DDC_PD_HI_BIT 13
`define DDC_PD_LO_BIT 12
`define DDC_DATA_MSB 11
`define DDC_LINK_MAX_MHZ 30
`define DDC_PIN_W 7
`define DDC_PIN_FRAME 0
`define DDC_PIN_ZERO 1
`define DDC_PIN_LOAD 2
`define DDC_PIN_SLEEP 3
`define DDC_PIN_CHAIN 4
`define DDC_PIN_BUF_A 5
`define DDC_PIN_BUF_B 6
`define DDC_PIN_RESET 7'h79
`endif

// [common/ddc_pkg.sv]
// types of the dual dac serial control block
// assumes ddc_consts.svh on the include path
`include "ddc_consts.svh"
package ddc_pkg;
  typedef enum logic [1:0] {
    PD_NORMAL = 2'h0,
    PD_PULL_LOW = 2'h1,
    PD_PULL_WEAK = 2'h2,
    PD_HIZ = 2'h3
  } ddc_pd_mode_e;
  typedef enum logic {
    STG_ASLEEP = 1'h0,
    STG_AWAKE = 1'h1
  } ddc_stage_e;
  typedef logic [`DDC_CODE_W-1:0] ddc_code_t;
  typedef struct packed {
    logic [`DDC_CNT_W-1:0] cnt;
    logic [`DDC_WORD_W-1:0] shift;
  } ddc_frame_s;
  typedef struct packed {
    logic [`DDC_WORD_W-1:0] word;
    logic tgl;
  } ddc_hold_s;
  typedef struct packed {
    logic [`DDC_PIN_W-1:0] pin_m;
    logic [`DDC_PIN_W-1:0] pin_s;
    logic frame_d;
    logic tgl_m;
    logic tgl_s;
    logic tgl_d;
    ddc_stage_e stage;
    ddc_code_t input_a;
    ddc_code_t input_b;
    ddc_code_t dac_a;
    ddc_code_t dac_b;
    logic new_a;
    logic new_b;
    ddc_pd_mode_e pd_a;
    ddc_pd_mode_e pd_b;
    logic [1:0] ref_buf;
    logic so_en;
    logic [1:0] hiz;
    logic [1:0] pull;
  } ddc_core_s;
endpackage

// [common/ddc_link_if.sv]
// carrier between the link-clock receiver and the core
// assumes the receiver drives, the core only reads
`timescale 1ns/1ps
`include "ddc_consts.svh"
interface ddc_link_if;
  logic [`DDC_WORD_W-1:0] word;
  logic done_tgl;
  logic serial_bit;
  modport link (output word, output done_tgl, output serial_bit);
  modport core (input word, input done_tgl, input serial_bit);
endinterface

// [rtl/ddc_link_rx.sv]
// serial receiver on the host's serial clock, falling edges
// assumes the clock runs only while the frame select is low
`timescale 1ns/1ps
`include "ddc_consts.svh"
module ddc_link_rx (
  input wire logic link_clk_i,
  input wire logic reset_n_i,
  input wire logic frame_sel_n_i,
  input wire logic serial_in_i,
  ddc_link_if.link lnk
);
  ddc_pkg::ddc_frame_s frm;
  ddc_pkg::ddc_frame_s next_frm;
  ddc_pkg::ddc_hold_s hold;
  ddc_pkg::ddc_hold_s next_hold;
  logic frm_rst_n;

  // frame state ends with the frame select rising, no clock needed
  assign frm_rst_n = reset_n_i & ~frame_sel_n_i;

  always_comb begin
    next_frm = frm;
    next_hold = hold;
    next_frm.shift = {frm.shift[`DDC_WORD_W-2:0], serial_in_i};
    if (frm.cnt != `DDC_CNT_FULL) begin
      next_frm.cnt = frm.cnt + 5'h01;
    end
    if (frm.cnt == `DDC_CNT_LAST) begin
      next_hold.word = next_frm.shift;
      next_hold.tgl = ~hold.tgl;
    end
  end

  always_ff @(negedge link_clk_i or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      frm <= '0;
    end else begin
      frm <= next_frm;
    end
  end

  always_ff @(negedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold <= '0;
    end else begin
      hold <= next_hold;
    end
  end

  assign lnk.word = hold.word;
  assign lnk.done_tgl = hold.tgl;
  assign lnk.serial_bit = frm.shift[`DDC_WORD_W-1];
endmodule // ddc_link_rx

// [rtl/ddc_top.sv]
// core of the dual dac serial control block
// assumes pins arrive asynchronously; link logic sits in ddc_link_rx
`timescale 1ns/1ps
`include "ddc_consts.svh"
module ddc_top #(
  parameter int RES_BITS = `DDC_RES_DEFAULT,
  parameter int SEL_BIT = `DDC_SEL_BIT,
  parameter int PD_HI_BIT = `DDC_PD_HI_BIT,
  parameter int PD_LO_BIT = `DDC_PD_LO_BIT,
  parameter int DATA_MSB = `DDC_DATA_MSB
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic frame_sel_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_en_o,
  input wire logic zero_all_n_i,
  input wire logic load_outputs_n_i,
  input wire logic hw_sleep_n_i,
  input wire logic chain_enable_i,
  input wire logic ref_buf_a_i,
  input wire logic ref_buf_b_i,
  output logic [`DDC_CODE_W-1:0] dac_a_code_o,
  output logic [`DDC_CODE_W-1:0] dac_b_code_o,
  output logic [`DDC_CODE_W-1:0] input_a_code_o,
  output logic [`DDC_CODE_W-1:0] input_b_code_o,
  output logic [1:0] pending_o,
  output logic [1:0] pd_mode_a_o,
  output logic [1:0] pd_mode_b_o,
  output logic [1:0] ref_buf_o,
  output logic [1:0] out_hiz_o,
  output logic [1:0] out_pull_low_o,
  output logic link_awake_o
);
  ddc_pkg::ddc_core_s st;
  ddc_pkg::ddc_core_s next_st;
  ddc_link_if lnk ();
  logic [`DDC_PIN_W-1:0] pins;
  logic [`DDC_CODE_W-1:0] rx_code;
  logic word_done;
  logic frame_fall;
  logic frame_rise;
  logic sel_b;
  logic zero_req;
  logic load_req;
  logic sleep_req;
  ddc_pkg::ddc_pd_mode_e rx_pd;

  ddc_link_rx u_link_rx (
    .link_clk_i(link_clk_i),
    .reset_n_i(reset_n_i),
    .frame_sel_n_i(frame_sel_n_i),
    .serial_in_i(serial_in_i),
    .lnk(lnk)
  );

  // pin vector for the two-stage synchroniser
  always_comb begin
    pins = '0;
    pins[`DDC_PIN_FRAME] = frame_sel_n_i;
    pins[`DDC_PIN_ZERO] = zero_all_n_i;
    pins[`DDC_PIN_LOAD] = load_outputs_n_i;
    pins[`DDC_PIN_SLEEP] = hw_sleep_n_i;
    pins[`DDC_PIN_CHAIN] = chain_enable_i;
    pins[`DDC_PIN_BUF_A] = ref_buf_a_i;
    pins[`DDC_PIN_BUF_B] = ref_buf_b_i;
  end

  // data field of the captured word, right aligned, zero above the resolution
  genvar gi;
  generate
    for (gi = 0; gi < `DDC_CODE_W; gi++) begin : g_code
      if (gi < RES_BITS) begin : g_used
        assign rx_code[gi] = lnk.word[DATA_MSB - RES_BITS + 1 + gi];
      end else begin : g_zero
        assign rx_code[gi] = 1'h0;
      end
    end
  endgenerate

  // channel select and power-down field positions come from parameters
  assign sel_b = lnk.word[SEL_BIT];
  assign rx_pd = ddc_pkg::ddc_pd_mode_e'({lnk.word[PD_HI_BIT], lnk.word[PD_LO_BIT]});

  // events and levels seen after synchronisation
  assign word_done = st.tgl_s ^ st.tgl_d;
  assign frame_fall = st.frame_d & ~st.pin_s[`DDC_PIN_FRAME];
  assign frame_rise = ~st.frame_d & st.pin_s[`DDC_PIN_FRAME];
  assign zero_req = ~st.pin_s[`DDC_PIN_ZERO];
  assign load_req = ~st.pin_s[`DDC_PIN_LOAD];
  assign sleep_req = ~st.pin_s[`DDC_PIN_SLEEP];

  always_comb begin
    next_st = st;
    next_st.pin_m = pins;
    next_st.pin_s = st.pin_m;
    next_st.frame_d = st.pin_s[`DDC_PIN_FRAME];
    next_st.tgl_m = lnk.done_tgl;
    next_st.tgl_s = st.tgl_m;
    next_st.tgl_d = st.tgl_s;

    // input stage wake state
    case (st.stage)
      ddc_pkg::STG_ASLEEP: begin
        if (frame_fall) begin
          next_st.stage = ddc_pkg::STG_AWAKE;
        end
      end
      ddc_pkg::STG_AWAKE: begin
        if (word_done || frame_rise) begin
          next_st.stage = ddc_pkg::STG_ASLEEP;
        end
      end
      default: begin
        next_st.stage = ddc_pkg::STG_ASLEEP;
      end
    endcase

    // a finished word lands in the selected input register
    if (word_done) begin
      if (sel_b) begin
        next_st.input_b = rx_code;
        next_st.pd_b = rx_pd;
      end else begin
        next_st.input_a = rx_code;
        next_st.pd_a = rx_pd;
      end
    end

    // load copies while held low; a write in the same cycle stays pending
    if (load_req) begin
      next_st.dac_a = st.input_a;
      next_st.dac_b = st.input_b;
      next_st.new_a = 1'h0;
      next_st.new_b = 1'h0;
    end
    if (word_done && !sel_b) begin
      next_st.new_a = 1'h1;
    end
    if (word_done && sel_b) begin
      next_st.new_b = 1'h1;
    end

    // clear dominates writes and loads
    if (zero_req) begin
      next_st.input_a = '0;
      next_st.input_b = '0;
      next_st.dac_a = '0;
      next_st.dac_b = '0;
      next_st.new_a = 1'h0;
      next_st.new_b = 1'h0;
    end

    // straps and output stage control
    next_st.ref_buf[0] = st.pin_s[`DDC_PIN_BUF_A];
    next_st.ref_buf[1] = st.pin_s[`DDC_PIN_BUF_B];
    next_st.so_en = st.pin_s[`DDC_PIN_CHAIN];
    if (sleep_req) begin
      next_st.hiz = 2'h3;
      next_st.pull = 2'h0;
    end else begin
      next_st.hiz[0] = (st.pd_a == ddc_pkg::PD_HIZ);
      next_st.hiz[1] = (st.pd_b == ddc_pkg::PD_HIZ);
      next_st.pull[0] = (st.pd_a == ddc_pkg::PD_PULL_LOW) ||
                        (st.pd_a == ddc_pkg::PD_PULL_WEAK);
      next_st.pull[1] = (st.pd_b == ddc_pkg::PD_PULL_LOW) ||
                        (st.pd_b == ddc_pkg::PD_PULL_WEAK);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.pin_m <= `DDC_PIN_RESET;
      st.pin_s <= `DDC_PIN_RESET;
      st.frame_d <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign serial_out_o = lnk.serial_bit;
  assign serial_out_en_o = st.so_en;
  assign dac_a_code_o = st.dac_a;
  assign dac_b_code_o = st.dac_b;
  assign input_a_code_o = st.input_a;
  assign input_b_code_o = st.input_b;
  assign pending_o = {st.new_b, st.new_a};
  assign pd_mode_a_o = st.pd_a;
  assign pd_mode_b_o = st.pd_b;
  assign ref_buf_o = st.ref_buf;
  assign out_hiz_o = st.hiz;
  assign out_pull_low_o = st.pull;
  assign link_awake_o = (st.stage == ddc_pkg::STG_AWAKE);
endmodule // ddc_top

// [sim/ddc_top_sva.sv]
// assertions on the ports of ddc_top
// assumes it is bound into every ddc_top instance
`timescale 1ns/1ps
`include "ddc_consts.svh"
module ddc_top_sva (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic frame_sel_n_i,
  input wire logic zero_all_n_i,
  input wire logic load_outputs_n_i,
  input wire logic hw_sleep_n_i,
  input wire logic chain_enable_i,
  input wire logic ref_buf_a_i,
  input wire logic ref_buf_b_i,
  input wire logic serial_out_en_o,
  input wire logic [`DDC_CODE_W-1:0] dac_a_code_o,
  input wire logic [`DDC_CODE_W-1:0] dac_b_code_o,
  input wire logic [`DDC_CODE_W-1:0] input_a_code_o,
  input wire logic [`DDC_CODE_W-1:0] input_b_code_o,
  input wire logic [1:0] ref_buf_o,
  input wire logic [1:0] out_hiz_o,
  input wire logic [1:0] out_pull_low_o,
  input wire logic link_awake_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence clr_held; !zero_all_n_i [*4]; endsequence
  sequence load_held; (!load_outputs_n_i && zero_all_n_i) [*4]; endsequence
  sequence link_idle; (frame_sel_n_i && zero_all_n_i) [*8]; endsequence
  zero_all_a: assert property (clr_held |-> (dac_a_code_o | dac_b_code_o | input_a_code_o
    | input_b_code_o) == 12'h000) else $error("clear left a register set");
  load_copy_a: assert property (load_held |-> dac_a_code_o == $past(input_a_code_o)
    && dac_b_code_o == $past(input_b_code_o)) else $error("load did not copy");
  sleep_hiz_a: assert property (!hw_sleep_n_i [*4] |-> out_hiz_o == 2'h3
    && out_pull_low_o == 2'h0) else $error("sleep pin not obeyed");
  frame_wake_a: assert property ($fell(frame_sel_n_i) |-> ##[1:5] link_awake_o)
    else $error("input stage did not wake");
  stage_sleep_a: assert property (frame_sel_n_i [*6] |-> !link_awake_o)
    else $error("input stage awake between frames");
  input_hold_a: assert property (link_idle |-> $stable(input_a_code_o)
    && $stable(input_b_code_o)) else $error("input register changed without frame");
  ref_strap_a: assert property ($stable({ref_buf_b_i, ref_buf_a_i}) [*5]
    |-> ref_buf_o == {ref_buf_b_i, ref_buf_a_i}) else $error("reference strap lost");
  chain_en_a: assert property ($stable(chain_enable_i) [*5]
    |-> serial_out_en_o == chain_enable_i) else $error("chain strap lost");
endmodule // ddc_top_sva
bind ddc_top ddc_top_sva u_ddc_top_sva (.*);

// [sim/ddc_host_model.sv]
// host serial port model on the link side of ddc_top
// assumes the bench calls send and leaves these pins alone
`timescale 1ns/1ps
module ddc_host_model (
  output logic link_clk_o,
  output logic frame_sel_n_o,
  output logic serial_in_o,
  input wire logic serial_out_i
);
  logic so_last;
  initial begin
    link_clk_o = 1'b1;
    frame_sel_n_o = 1'b1;
    serial_in_o = 1'b0;
    so_last = 1'b0;
  end
  // clock stands high between frames; 48 ns period
  task automatic send(input logic [15:0] w, input int nbits);
    frame_sel_n_o = 1'b0;
    #24;
    for (int i = 0; i < nbits; i++) begin
      serial_in_o = w[15-i];
      #12 link_clk_o = 1'b0;
      #24 link_clk_o = 1'b1;
      #12;
    end
    so_last = serial_out_i;
    frame_sel_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    #100;
  endtask
endmodule // ddc_host_model

// [sim/tb.sv]
// self-checking bench for ddc_top driven by a host serial model
// assumes design, checker and host model are compiled first
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic zero_n = 1'b1;
  logic load_n = 1'b1;
  logic sleep_n = 1'b1;
  logic chain = 1'b0;
  logic buf_a = 1'b0;
  logic buf_b = 1'b0;
  logic lclk, fsel_n, sin, sout, sout_en, awake;
  logic [11:0] dac_a, dac_b, in_a, in_b, exp_a, exp_b;
  logic [1:0] pend, pd_a, pd_b, ref_buf, hiz, pull, m;
  int miscompares = 0;
  int compares = 0;
  always #5 sys_clk = ~sys_clk;
  ddc_top u_ddc_top (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .link_clk_i(lclk),
    .frame_sel_n_i(fsel_n), .serial_in_i(sin), .serial_out_o(sout),
    .serial_out_en_o(sout_en), .zero_all_n_i(zero_n), .load_outputs_n_i(load_n),
    .hw_sleep_n_i(sleep_n), .chain_enable_i(chain), .ref_buf_a_i(buf_a),
    .ref_buf_b_i(buf_b), .dac_a_code_o(dac_a), .dac_b_code_o(dac_b),
    .input_a_code_o(in_a), .input_b_code_o(in_b), .pending_o(pend), .pd_mode_a_o(pd_a),
    .pd_mode_b_o(pd_b), .ref_buf_o(ref_buf), .out_hiz_o(hiz), .out_pull_low_o(pull),
    .link_awake_o(awake));
  ddc_host_model u_ddc_host_model (.link_clk_o(lclk), .frame_sel_n_o(fsel_n),
    .serial_in_o(sin), .serial_out_i(sout));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pins(input logic z, input logic l, input logic s);
    @(posedge sys_clk);
    zero_n <= z;
    load_n <= l;
    sleep_n <= s;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic wr(input logic sel, input logic [1:0] pd, input logic [11:0] d);
    u_ddc_host_model.send({sel, 1'b0, pd, d}, 16);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(5183));
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      exp_a = (k == 0) ? 12'hFFF : 12'($urandom);
      exp_b = (k == 0) ? 12'h000 : 12'($urandom);
      wr(1'b0, 2'h0, exp_a);
      wr(1'b1, 2'h0, exp_b);
      check({in_b, in_a}, {exp_b, exp_a});
      check(pend, 2'h3);
      check(u_ddc_host_model.so_last, 1'b1);
      pins(1'b1, 1'b0, 1'b1);
      pins(1'b1, 1'b1, 1'b1);
      check({dac_b, dac_a}, {exp_b, exp_a});
      check(pend, 2'h0);
    end
    $display("test write_load done");
    for (int k = 0; k < 4; k++) begin
      u_ddc_host_model.send({4'h0, 12'($urandom)}, (k == 0) ? 15 : 1 + $urandom % 14);
      repeat (2) @(posedge sys_clk);
      check({pend, in_a}, {2'h0, exp_a});
      check(awake, 1'b0);
    end
    $display("test abort done");
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(1'b0, m, exp_a);
      check({pd_a, hiz, pull}, {m, 1'b0, m == 2'h3, 1'b0, m == 2'h1 || m == 2'h2});
      pins(1'b1, 1'b1, 1'b0);
      check({pd_a, hiz, pull}, {m, 2'h3, 2'h0});
      pins(1'b1, 1'b1, 1'b1);
    end
    $display("test sleep done");
    wr(1'b1, 2'h2, ~exp_b);
    check({pd_b, pull[1]}, {2'h2, 1'b1});
    pins(1'b0, 1'b1, 1'b1);
    check({pend, in_b, in_a, dac_b, dac_a}, 64'h0);
    pins(1'b1, 1'b1, 1'b1);
    $display("test clear done");
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      buf_a <= 1'($urandom);
      buf_b <= 1'($urandom);
      chain <= k[0];
      repeat (5) @(posedge sys_clk);
      check({ref_buf, sout_en}, {buf_b, buf_a, chain});
    end
    $display("test straps done");
    tally_and_finish();
  end
endmodule // tb
